// File: aic_pkg.sv
/*
  Shared constants and types of the task-file command engine: register
  indices, command codes, status and error bit positions, timing figures,
  the media input bundle and the engine state record.
  Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package aic_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PD_UNIT_NS = 5000000;
  localparam int PD_UNIT_CYC = PD_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SECT_LAST_WORD = 8'hFF;
  localparam logic [8:0] MAX_SECTORS = 9'h100;

  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_DATA = 6'h00;
  localparam logic [5:0] IDX_FEAT = 6'h01;
  localparam logic [5:0] IDX_SCNT = 6'h02;
  localparam logic [5:0] IDX_SNUM = 6'h03;
  localparam logic [5:0] IDX_CYLL = 6'h04;
  localparam logic [5:0] IDX_CYLH = 6'h05;
  localparam logic [5:0] IDX_DH = 6'h06;
  localparam logic [5:0] IDX_CMD = 6'h07;
  localparam logic [5:0] IDX_STAT = 6'h08;
  localparam logic [5:0] IDX_ERR = 6'h09;
  localparam logic [5:0] IDX_CFG = 6'h0A;
  localparam logic [5:0] IDX_GEOM = 6'h0B;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_IDLE_A = 8'h97;
  localparam logic [7:0] CMD_IDLE_B = 8'hE3;
  localparam logic [7:0] CMD_IDLI_A = 8'h95;
  localparam logic [7:0] CMD_IDLI_B = 8'hE1;
  localparam logic [7:0] CMD_INIT = 8'h91;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_RDBUF = 8'hE4;
  localparam logic [7:0] CMD_RDDMA = 8'hC8;
  localparam logic [7:0] CMD_RDMUL = 8'hC4;

  // ----------------------------------------------------------------------
  // Field positions and error register values
  // ----------------------------------------------------------------------
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_CORR = 2;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_ABRT = 2;
  localparam int DH_LBA = 6;
  localparam int CFG_MEN = 8;
  localparam int CFG_8BIT = 9;
  localparam logic [7:0] ERR_ABRT = 8'h04;
  localparam logic [7:0] ERR_UNC = 8'h40;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    AIC_S_IDLE = 3'h0,
    AIC_S_EXEC = 3'h1,
    AIC_S_LOAD = 3'h3,
    AIC_S_XFER = 3'h2,
    AIC_S_NEXT = 3'h6
  } aic_st_t;

  typedef enum logic [1:0] {
    AIC_K_BUF = 2'h0,
    AIC_K_MUL = 2'h1,
    AIC_K_DMA = 2'h2
  } aic_kind_t;

  typedef struct packed {
    logic wvalid;
    logic [15:0] word;
    logic done;
    logic err_corr;
    logic err_unc;
  } aic_med_in_t;

  typedef struct packed {
    aic_st_t st;
    aic_kind_t kind;
    logic wr_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] cyll;
    logic [7:0] cylh;
    logic [7:0] dh;
    logic [7:0] cmd;
    logic [7:0] err;
    logic [7:0] blk;
    logic men;
    logic eight;
    logic [7:0] spt;
    logic [4:0] heads;
    logic drq;
    logic errf;
    logic corr;
    logic irq;
    logic dmarq;
    logic [15:0] dma_data;
    logic iord_q;
    logic [8:0] remain;
    logic [8:0] blkleft;
    logic blkstart;
    logic stop;
    logic [27:0] lba;
    logic lbam;
    logic [7:0] ptr;
    logic med_req;
    logic pd_en;
    logic [7:0] pd_units;
    logic [7:0] pd_left;
    logic [19:0] tick;
    logic pdown;
  } aic_state_t;

  localparam aic_state_t AIC_STATE_RST = '0;

endpackage

// File: aic_engine.sv
/*
  Task-file command engine: idle, idle immediate, drive parameters, NOP,
  buffer read, DMA read and multiple-sector read, with an AXI4-Lite slave.
  Assumes a media port that streams 256 words per requested sector and a
  host that drives the DMA acknowledge and read strobe synchronously.
*/
// Register access over AXI4-Lite is this design's own decision.
module aic_engine
  import aic_pkg::*;
#(
  parameter int PD_UNIT_CYCLES = PD_UNIT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Host link
  output logic intrq,
  output logic dmarq,
  input wire logic dmack_n,
  input wire logic iord_n,
  output logic [15:0] dma_data,
  // Media port
  output logic med_req,
  output logic [27:0] med_lba,
  output logic med_lba_mode,
  input wire aic_med_in_t med_in,
  // Power state
  output logic powered_down
);

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  aic_state_t s, next_s;
  logic [15:0] sect_mem [256];
  logic [15:0] rd_word;
  logic [5:0] widx, ridx;
  logic wr_fire, rd_fire, cmd_fire, bsy;
  logic pop, set_irq, clr_irq, data_ok;
  logic [8:0] cnt9, rest;
  logic [7:0] stat;

  assign widx = awaddr[7:2];
  assign ridx = araddr[7:2];
  assign wr_fire = s.wr_rdy && awvalid && wvalid;
  assign rd_fire = s.arready && arvalid;
  assign bsy = (s.st != AIC_S_IDLE) && (s.st != AIC_S_XFER);
  assign cmd_fire = wr_fire && (widx == IDX_CMD) && wstrb[0] &&
                    (s.st == AIC_S_IDLE);
  assign cnt9 = (s.scnt == 8'h00) ? MAX_SECTORS : {1'b0, s.scnt};
  assign rest = s.remain - 9'h001;
  assign rd_word = sect_mem[s.ptr];
  assign data_ok = (ridx != IDX_DATA) ||
                   ((s.st == AIC_S_XFER) && (s.kind != AIC_K_DMA));
  always_comb begin
    stat = 8'h00;
    stat[ST_BSY] = bsy;
    stat[ST_RDY] = !s.pdown;
    stat[ST_DRQ] = s.drq;
    stat[ST_CORR] = s.corr;
    stat[ST_ERR] = s.errf;
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    set_irq = 1'b0;
    clr_irq = cmd_fire || (rd_fire && (ridx == IDX_STAT));
    pop = 1'b0;
    next_s.iord_q = iord_n;
    next_s.dma_data = rd_word;
    // Write channel: address and data are taken together in one beat.
    next_s.wr_rdy = awvalid && wvalid && !s.wr_rdy && !s.bvalid;
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = (widx > IDX_GEOM) ? RESP_SLVERR : RESP_OKAY;
      if (wstrb[0] && s.st == AIC_S_IDLE) begin
        unique case (widx)
          IDX_FEAT: next_s.feat = wdata[7:0];
          IDX_SCNT: next_s.scnt = wdata[7:0];
          IDX_SNUM: next_s.snum = wdata[7:0];
          IDX_CYLL: next_s.cyll = wdata[7:0];
          IDX_CYLH: next_s.cylh = wdata[7:0];
          IDX_DH: next_s.dh = wdata[7:0];
          IDX_CFG: next_s.blk = wdata[7:0];
          default: ;
        endcase
      end
      if (wstrb[1] && widx == IDX_CFG && s.st == AIC_S_IDLE) begin
        next_s.men = wdata[CFG_MEN];
        next_s.eight = wdata[CFG_8BIT];
      end
    end
    // Read channel: data reads wait until a sector is ready to move.
    next_s.arready = arvalid && !s.arready && !s.rvalid && data_ok;
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = (ridx > IDX_GEOM) ? RESP_SLVERR : RESP_OKAY;
      unique case (ridx)
        IDX_DATA: next_s.rdata = {16'h0000, rd_word};
        IDX_FEAT: next_s.rdata = {24'h0, s.feat};
        IDX_SCNT: next_s.rdata = {24'h0, s.scnt};
        IDX_SNUM: next_s.rdata = {24'h0, s.snum};
        IDX_CYLL: next_s.rdata = {24'h0, s.cyll};
        IDX_CYLH: next_s.rdata = {24'h0, s.cylh};
        IDX_DH: next_s.rdata = {24'h0, s.dh};
        IDX_STAT: next_s.rdata = {24'h0, stat};
        IDX_ERR: next_s.rdata = {24'h0, s.err};
        IDX_CFG: next_s.rdata = {22'h0, s.eight, s.men, s.blk};
        IDX_GEOM: next_s.rdata = {19'h0, s.heads, s.spt};
        default: next_s.rdata = 32'h0000_0000;
      endcase
      pop = (ridx == IDX_DATA);
    end
    // A DMA word leaves at the end of each read strobe.
    if (s.dmarq && !dmack_n && !s.iord_q && iord_n) begin
      pop = 1'b1;
    end
    // Power-down timer runs only while no command is in progress.
    if (s.pd_en && !s.pdown && s.st == AIC_S_IDLE) begin
      if (s.tick == 20'(PD_UNIT_CYCLES - 1)) begin
        next_s.tick = 20'h00000;
        if (s.pd_left <= 8'h01) begin
          next_s.pdown = 1'b1;
        end else begin
          next_s.pd_left = s.pd_left - 8'h01;
        end
      end else begin
        next_s.tick = s.tick + 20'h00001;
      end
    end
    if (cmd_fire) begin
      next_s.tick = 20'h00000;
      next_s.pd_left = s.pd_units;
      next_s.pdown = 1'b0;
      next_s.cmd = wdata[7:0];
      next_s.st = AIC_S_EXEC;
      next_s.err = 8'h00;
      next_s.errf = 1'b0;
      next_s.corr = 1'b0;
      next_s.drq = 1'b0;
      next_s.stop = 1'b0;
    end
    unique case (s.st)
      AIC_S_IDLE: ;
      AIC_S_EXEC: begin
        next_s.st = AIC_S_IDLE;
        next_s.ptr = 8'h00;
        next_s.lba = {s.dh[3:0], s.cylh, s.cyll, s.snum};
        next_s.lbam = s.dh[DH_LBA];
        next_s.remain = cnt9;
        next_s.blkstart = 1'b1;
        set_irq = 1'b1;
        unique case (s.cmd)
          CMD_IDLE_A, CMD_IDLE_B: begin
            next_s.pd_en = (s.scnt != 8'h00);
            next_s.pd_units = s.scnt;
            next_s.pd_left = s.scnt;
          end
          CMD_IDLI_A, CMD_IDLI_B: ;
          CMD_INIT: begin
            next_s.spt = s.scnt;
            next_s.heads = {1'b0, s.dh[3:0]} + 5'h01;
          end
          CMD_RDBUF: begin
            next_s.kind = AIC_K_BUF;
            next_s.drq = 1'b1;
            next_s.st = AIC_S_XFER;
          end
          CMD_RDDMA: begin
            if (s.eight) begin
              next_s.err = ERR_ABRT;
              next_s.errf = 1'b1;
            end else begin
              set_irq = 1'b0;
              next_s.kind = AIC_K_DMA;
              next_s.blkleft = cnt9;
              next_s.med_req = 1'b1;
              next_s.st = AIC_S_LOAD;
            end
          end
          CMD_RDMUL: begin
            if (!s.men || s.blk == 8'h00) begin
              next_s.err = ERR_ABRT;
              next_s.errf = 1'b1;
            end else begin
              set_irq = 1'b0;
              next_s.kind = AIC_K_MUL;
              next_s.blkleft = (cnt9 < {1'b0, s.blk}) ? cnt9 :
                               {1'b0, s.blk};
              next_s.med_req = 1'b1;
              next_s.st = AIC_S_LOAD;
            end
          end
          default: begin
            next_s.err = ERR_ABRT;
            next_s.errf = 1'b1;
          end
        endcase
      end
      AIC_S_LOAD: begin
        if (med_in.wvalid && s.med_req) begin
          next_s.ptr = s.ptr + 8'h01;
        end
        if (med_in.done && s.med_req) begin
          next_s.med_req = 1'b0;
          next_s.ptr = 8'h00;
          next_s.snum = s.stop ? s.snum : s.lba[7:0];
          next_s.cyll = s.stop ? s.cyll : s.lba[15:8];
          next_s.cylh = s.stop ? s.cylh : s.lba[23:16];
          next_s.dh = s.stop ? s.dh : {s.dh[7:4], s.lba[27:24]};
          next_s.st = AIC_S_XFER;
          next_s.corr = s.corr || med_in.err_corr;
          if (med_in.err_unc) begin
            next_s.err = ERR_UNC;
            next_s.errf = 1'b1;
            next_s.stop = 1'b1;
          end
          if (s.kind == AIC_K_DMA) begin
            if (med_in.err_unc) begin
              next_s.st = AIC_S_IDLE;
              set_irq = 1'b1;
            end else begin
              next_s.dmarq = 1'b1;
            end
          end else if (s.blkstart) begin
            next_s.drq = 1'b1;
            set_irq = 1'b1;
          end
        end
      end
      AIC_S_XFER: begin
        if (pop) begin
          next_s.ptr = s.ptr + 8'h01;
          if (s.ptr == SECT_LAST_WORD) begin
            next_s.dmarq = 1'b0;
            next_s.st = AIC_S_NEXT;
            if (s.kind == AIC_K_BUF) begin
              next_s.drq = 1'b0;
              next_s.st = AIC_S_IDLE;
            end
          end
        end
      end
      AIC_S_NEXT: begin
        next_s.remain = rest;
        next_s.lba = s.lba + 28'h0000001;
        if (s.remain == 9'h001 || (s.stop && s.blkleft == 9'h001)) begin
          next_s.drq = 1'b0;
          next_s.st = AIC_S_IDLE;
          set_irq = (s.kind == AIC_K_DMA);
        end else begin
          next_s.med_req = 1'b1;
          next_s.st = AIC_S_LOAD;
          if (s.blkleft == 9'h001) begin
            // The short last block falls out of the minimum below.
            next_s.blkleft = (rest < {1'b0, s.blk}) ? rest :
                             {1'b0, s.blk};
            next_s.blkstart = 1'b1;
            next_s.drq = 1'b0;
          end else begin
            next_s.blkleft = s.blkleft - 9'h001;
            next_s.blkstart = 1'b0;
          end
        end
      end
      default: next_s.st = AIC_S_IDLE;
    endcase
    // An interrupt raised in the cycle of a status read is kept.
    next_s.irq = (s.irq && !clr_irq) || set_irq;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= AIC_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // The buffer is not reset, so flawed data stays readable after errors.
  always_ff @(posedge aclk) begin
    if (s.st == AIC_S_LOAD && s.med_req && med_in.wvalid) begin
      sect_mem[s.ptr] <= med_in.word;
    end
  end

  assign awready = s.wr_rdy;
  assign wready = s.wr_rdy;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign intrq = s.irq;
  assign dmarq = s.dmarq;
  assign dma_data = s.dma_data;
  assign med_req = s.med_req;
  assign med_lba = s.lba;
  assign med_lba_mode = s.lbam;
  assign powered_down = s.pdown;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  idle_cmd_a: assert property (cmd_fire && wdata[7:0] == CMD_IDLE_A |=>
    bsy ##1 (s.irq && !bsy && !s.errf))
    else $error("idle command did not complete with interrupt");
  idle_imm_a: assert property (cmd_fire && wdata[7:0] == CMD_IDLI_B |=>
    ##1 (s.st == AIC_S_IDLE && !s.errf && s.irq))
    else $error("idle immediate did not complete cleanly");
  idle_timer_a: assert property (cmd_fire && wdata[7:0] == CMD_IDLE_B |=>
    ##1 (s.pd_en == (s.scnt != 8'h00)))
    else $error("power-down enable does not follow sector count");
  init_geom_a: assert property (cmd_fire && wdata[7:0] == CMD_INIT |=>
    ##1 (s.spt == s.scnt && s.heads == {1'b0, s.dh[3:0]} + 5'h01))
    else $error("drive geometry not taken from task file");
  nop_abort_a: assert property (cmd_fire && wdata[7:0] == CMD_NOP |=>
    ##1 (s.errf && s.err[ER_ABRT] && s.irq))
    else $error("NOP did not abort");
  dma_eight_a: assert property (cmd_fire && wdata[7:0] == CMD_RDDMA &&
    s.eight |=> ##1 (s.err[ER_ABRT] && !s.dmarq && s.st == AIC_S_IDLE))
    else $error("DMA read not aborted in 8-bit mode");
  dma_busy_a: assert property (cmd_fire && wdata[7:0] == CMD_RDDMA &&
    !s.eight |=> bsy ##1 (bsy && s.med_req))
    else $error("DMA read did not hold busy while filling");
  mul_reject_a: assert property (cmd_fire && wdata[7:0] == CMD_RDMUL &&
    (!s.men || s.blk == 8'h00) |=> ##1 (s.err[ER_ABRT] && !s.drq))
    else $error("multiple read not rejected");
  dmarq_ready_a: assert property (s.dmarq |->
    s.st == AIC_S_XFER && s.kind == AIC_K_DMA)
    else $error("DMA request without buffered data");
  dma_irq_a: assert property ($rose(s.irq) && s.kind == AIC_K_DMA |->
    s.st == AIC_S_IDLE)
    else $error("interrupt in the middle of a DMA read");
  blk_irq_a: assert property ($rose(s.drq) |-> s.irq)
    else $error("data request raised without interrupt");
  pd_wake_a: assert property (cmd_fire |=> !s.pdown && s.tick == 20'h0)
    else $error("command did not restart the power-down timer");

endmodule // aic_engine

// File: aic_dma_host.sv
/*
  DMA host model: acknowledges a raised DMA request, then strobes one word
  at a time and checks each word against the media stub's tag pattern.
  Assumes one DMA session per reset, starting at sector sec0.
*/
module aic_dma_host
  import aic_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Device link
  input wire logic dmarq,
  input wire logic [15:0] dma_data,
  output logic dmack_n = 1'b1,
  output logic iord_n = 1'b1,
  // Tallies
  input wire logic [7:0] sec0,
  output logic [15:0] n_words,
  output logic [15:0] n_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  // A spare acknowledge cycle and wide strobe spacing cover the data lag.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph <= 3'h0;
      dmack_n <= 1'b1;
      iord_n <= 1'b1;
      n_words <= 16'h0000;
      n_bad <= 16'h0000;
    end else if (ph != 3'h0) begin
      ph <= ph + 3'h1;
      iord_n <= 1'b1;
    end else if (dmarq && dmack_n) begin
      dmack_n <= 1'b0;
    end else if (dmarq) begin
      iord_n <= 1'b0;
      ph <= 3'h1;
      n_words <= n_words + 16'h0001;
      if (dma_data !== {sec0 + n_words[15:8], n_words[7:0]}) begin
        n_bad <= n_bad + 16'h0001;
      end
    end else begin
      dmack_n <= 1'b1;
    end
  end
endmodule // aic_dma_host

// File: testbench.sv
/*
  Bench for the task-file command engine: AXI4-Lite register tasks, a
  media stub that tags each word with its sector, and the DMA host model.
  Assumes the engine is built with a 20-cycle power-down unit.
*/
module testbench
  import aic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PD = 20;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h3;
  logic awready, bvalid, arready, rvalid, intrq, dmarq, dmack_n, iord_n;
  logic med_req, med_lba_mode, powered_down, wready;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [15:0] dma_data, n_words, n_bad;
  logic [27:0] med_lba;
  aic_med_in_t med_in = '0;
  logic [8:0] mcnt = 9'h000;
  logic mhold = 1'b0, e_on = 1'b0;
  logic [7:0] e_sec = 8'h00, sec0 = 8'h00;
  logic [16:0] ic [4] = '{17'h002E1, 17'h10297, 17'h000E3, 17'h00295};
  int n_fail = 0, n_tests = 0;

  initial begin
    forever #5 aclk = ~aclk;
  end

  aic_engine #(.PD_UNIT_CYCLES(PD)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .intrq(intrq),
    .dmarq(dmarq), .dmack_n(dmack_n), .iord_n(iord_n),
    .dma_data(dma_data), .med_req(med_req), .med_lba(med_lba),
    .med_lba_mode(med_lba_mode), .med_in(med_in),
    .powered_down(powered_down)
  );

  aic_dma_host host (
    .aclk(aclk), .aresetn(aresetn), .dmarq(dmarq), .dma_data(dma_data),
    .dmack_n(dmack_n), .iord_n(iord_n), .sec0(sec0), .n_words(n_words),
    .n_bad(n_bad)
  );

  // ------------------------------------------------------------
  // Media stub
  // ------------------------------------------------------------
  // Idle word lines toggle so a stale value is never mistaken for data.
  always @(posedge aclk) begin
    med_in.wvalid <= 1'b0;
    med_in.done <= 1'b0;
    med_in.err_unc <= 1'b0;
    med_in.err_corr <= 1'b0;
    med_in.word <= ~med_in.word;
    if (!med_req) begin
      mhold <= 1'b0;
    end else if (!mhold && mcnt != 9'h100) begin
      med_in.wvalid <= 1'b1;
      med_in.word <= {med_lba[7:0], mcnt[7:0]};
      mcnt <= mcnt + 9'h001;
    end else if (!mhold) begin
      med_in.done <= 1'b1;
      med_in.err_unc <= e_on && (med_lba[7:0] == e_sec);
      med_in.err_corr <= e_on && (med_lba[7:0] == e_sec - 8'h02);
      mcnt <= 9'h000;
      mhold <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] v);
    logic [1:0] er;
    er = (idx > IDX_GEOM) ? RESP_SLVERR : RESP_OKAY;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!awready);
    chk("wready", {31'h0, wready}, 32'h1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] idx);
    logic [1:0] er;
    er = (idx > IDX_GEOM) ? RESP_SLVERR : RESP_OKAY;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic wirq();
    int k;
    k = 0;
    while (intrq !== 1'b1 && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    chk("intrq", {31'h0, intrq}, 32'h1);
    rd(IDX_STAT);
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(IDX_CMD, {24'h0, c});
    wirq();
  endtask

  task automatic rsec(input logic [7:0] s0, input int n);
    for (int s = 0; s < n; s++) begin
      for (int i = 0; i < 256; i++) begin
        rd(IDX_DATA);
        chk("word", {16'h0, d[15:0]}, {16'h0, s0 + s[7:0], i[7:0]});
      end
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    give_verdict;
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("outs", {28'h0, intrq, dmarq, med_req, powered_down}, 32'h0);
    rd(IDX_STAT);
    chk("status", d, 32'h40);
    wr(6'h0C, 32'h0);
    rd(6'h0C);
    chk("unmapped", d, 32'h0);
    wr(IDX_SCNT, 32'h11);
    wr(IDX_DH, 32'h03);
    wr(IDX_CYLH, 32'h77);
    wr(IDX_FEAT, 32'h5A);
    cmd(CMD_INIT);
    rd(IDX_GEOM);
    chk("geometry", d, 32'h0000_0411);
    cmd(CMD_NOP);
    chk("nop status", {31'h0, d[ST_ERR]}, 32'h1);
    rd(IDX_ERR);
    chk("nop error", d & 32'hFF, {24'h0, ERR_ABRT});
    for (int j = 0; j < 4; j++) begin
      wr(IDX_SCNT, {24'h0, ic[j][15:8]});
      cmd(ic[j][7:0]);
      chk("idle status", d & 32'h81, 32'h0);
      repeat (20) @(posedge aclk);
      chk("early pd", {31'h0, powered_down}, 32'h0);
      repeat (3 * PD) @(posedge aclk);
      chk("pd", {31'h0, powered_down}, {31'h0, ic[j][16]});
    end
    for (int j = 0; j < 2; j++) begin
      wr(IDX_CFG, (j == 0) ? 32'h0000_0100 : 32'h0000_0002);
      cmd(CMD_RDMUL);
      rd(IDX_ERR);
      chk("mul abort", d & 32'hFF, {24'h0, ERR_ABRT});
    end
    wr(IDX_CFG, 32'h0000_0102);
    wr(IDX_SCNT, 32'h03);
    wr(IDX_SNUM, 32'h10);
    wr(IDX_CYLL, 32'h12);
    wr(IDX_CYLH, 32'h34);
    wr(IDX_DH, 32'h45);
    cmd(CMD_RDMUL);
    chk("blk1", d & 32'h89, 32'h08);
    chk("addr", {3'h0, med_lba_mode, med_lba}, 32'h1534_1210);
    rsec(8'h10, 2);
    wirq();
    chk("blk2", d & 32'h89, 32'h08);
    rsec(8'h12, 1);
    rd(IDX_STAT);
    chk("mul end", d & 32'h88, 32'h0);
    cmd(CMD_RDBUF);
    chk("buf", d & 32'h89, 32'h08);
    rsec(8'h12, 1);
    sec0 <= 8'h20;
    wr(IDX_SCNT, 32'h02);
    wr(IDX_SNUM, 32'h20);
    cmd(CMD_RDDMA);
    chk("dma words", {16'h0, n_words}, 32'h200);
    chk("dma bad", {16'h0, n_bad}, 32'h0);
    wr(IDX_CFG, 32'h0000_0302);
    cmd(CMD_RDDMA);
    rd(IDX_ERR);
    chk("dma abort", d & 32'hFF, {24'h0, ERR_ABRT});
    chk("dma idle", {16'h0, n_words}, 32'h200);
    wr(IDX_CFG, 32'h0000_0102);
    wr(IDX_SCNT, 32'h06);
    wr(IDX_SNUM, 32'h2E);
    e_sec <= 8'h30;
    e_on <= 1'b1;
    cmd(CMD_RDMUL);
    chk("corr posted", d & 32'h8D, 32'h0C);
    rsec(8'h2E, 2);
    wirq();
    chk("err posted", d & 32'h89, 32'h09);
    rsec(8'h30, 2);
    rd(IDX_STAT);
    chk("stopped", d & 32'h88, 32'h0);
    rd(IDX_SNUM);
    chk("err addr", d, 32'h30);
    rd(IDX_ERR);
    chk("unc", d & {24'h0, ERR_UNC}, {24'h0, ERR_UNC});
    give_verdict;
  end
endmodule // testbench
